// ==== hw/bsf_pkg.sv ====
// constants, states and carriers of the buck startup/protection controller
// assumes a 20 MHz core clock and millivolt-scaled comparator readings
package bsf_pkg;
    // clocking and switching tick
    localparam int CLK_HZ = 20000000;
    localparam int SW_HZ = 300000;
    localparam int TICK_CYC = CLK_HZ / SW_HZ;
    // intervals, in microseconds and in switching ticks
    localparam int SS_TIME_US = 4500;
    localparam int SS_TICKS = SS_TIME_US * (SW_HZ / 1000) / 1000;
    localparam int THRESHOLD_SET_CURRENT_TIME_US = 5000;
    localparam int THRESHOLD_SET_CURRENT_TICKS = THRESHOLD_SET_CURRENT_TIME_US * (SW_HZ / 1000) / 1000;
    // fallback timer when the switch node never drops (plain default)
    localparam int WD_TIME_NS = 500;
    localparam int WD_CYC = (WD_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // voltages in millivolts
    localparam logic [9:0] REF_MV = 10'h320;
    localparam logic [9:0] THR_MIN_MV = 10'h032;
    localparam logic [9:0] THR_MAX_MV = 10'h226;
    localparam logic [9:0] CLAMP_MV = 10'h258;
    localparam logic [2:0] OC_COUNT = 3'h4;
    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_THRESH = 4'h8;
    localparam logic CTRL_EN_RESET = 1'h1;
    localparam int CTRL_EN_BIT = 0;
    typedef enum logic [2:0] {ST_LOCKOUT, ST_THRSET, ST_SS, ST_RUN, ST_FAULT} bsf_state_type;
    typedef enum logic [2:0] {DRV_OFF, DRV_HS_ON, DRV_WAIT_SW, DRV_LS_ON, DRV_WAIT_LG} bsf_drv_type;
    // gate drive pair
    typedef struct packed {
        logic hs;
        logic ls;
    } bsf_gate_type;
    // single-bit comparator and status pins
    typedef struct packed {
        logic supply_ok;
        logic sw_node_low;
        logic ls_gate_low;
        logic pwm_req;
        logic prot_ls_on;
        logic sense_in_window;
    } bsf_pins_type;
endpackage

// ==== hw/bsf_ctrl.sv ====
// buck startup, dead-time and overcurrent control with an Avalon-MM slave
// assumes pin inputs are asynchronous and the analog loop lives outside
//
// Behaviour
// - switching tick runs at a fixed 300 kHz, not programmable
// - low-side turns on only after the switch node has dropped
// - high-side turns on only after the low-side gate has fallen
// - fallback timer forces low-side on if the switch node never drops
// - soft-start reference ramps linearly 0 to 800 mV over 4.5 ms
// - soft-start begins only above lockout and after threshold setting
// - overcurrent during soft-start aborts ramp, both gates off, latched
// - during soft-start low-side stays off until high-side first switches
// - if high-side never switched, low-side enabled when soft-start ends
// - startup mask gates only loop requests; protection may still drive low-side
// - overcurrent compared only while low-side is on
// - four consecutive first-level cycles trip; a clean cycle restarts the count
// - second level, 1.5 times first, trips at once
// - trip latches both gates off until supply passes through lockout
// - about 5 ms of test current, then the low-side pin voltage is held
// - first threshold held within 50..550 mV, second derived from it
// - 600 mV on the low-side pin ends setting at once with maximum thresholds
// - power ok released only after soft-start and while output in window
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module bsf_ctrl
#(
    parameter int WD_CYC_P = bsf_pkg::WD_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire bsf_pkg::bsf_pins_type pins_i,
    input wire logic [9:0] sw_node_mv_i,
    input wire logic [9:0] ls_gate_mv_i,
    output bsf_pkg::bsf_gate_type gate_o,
    output logic threshold_set_current_o,
    output logic [9:0] ref_mv_o,
    output logic power_ok_output_oe_o,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import bsf_pkg::*;

    logic rst_meta_reg, rstn_sync;
    bsf_pins_type pin_meta_reg, pin_reg;
    logic [19:0] mv_meta_reg, mv_reg;
    logic [9:0] sw_mv, ls_mv;
    logic [6:0] tick_cnt_reg, tick_cnt_next;
    logic tick;
    bsf_state_type st_reg, st_next;
    bsf_drv_type drv_reg, drv_next;
    logic [10:0] ivl_reg, ivl_next;
    logic [11:0] acc_reg, acc_next;
    logic [1:0] ls_hist_reg, ls_hist_next;
    logic [9:0] thr1_reg, thr1_next, thr2, ref_reg, ref_next;
    logic hs_started_reg, hs_started_next, oc_seen_reg, oc_seen_next;
    logic [2:0] oc_cnt_reg, oc_cnt_next;
    logic [7:0] wd_reg, wd_next;
    logic oc_eval, oc1, oc2, trip, run_ok, ls_mask;
    bsf_gate_type gate_next;
    logic pg_oe_next, thr_en_next;
    logic en_reg, en_next, resp_reg, resp_next;
    logic [31:0] rdata_reg, rdata_next;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_reg <= 1'h0;
            rstn_sync <= 1'h0;
        end
        else
        begin
            rst_meta_reg <= 1'h1;
            rstn_sync <= rst_meta_reg;
        end
    end

    // pin and comparator-code synchronisers; first stage read only by second
    always_ff @(posedge core_clk_i or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            pin_meta_reg <= '0;
            pin_reg <= '0;
            mv_meta_reg <= 20'h00000;
            mv_reg <= 20'h00000;
        end
        else
        begin
            pin_meta_reg <= pins_i;
            pin_reg <= pin_meta_reg;
            mv_meta_reg <= {sw_node_mv_i, ls_gate_mv_i};
            mv_reg <= mv_meta_reg;
        end
    end
    assign sw_mv = mv_reg[19:10];
    assign ls_mv = mv_reg[9:0];

    // overcurrent comparators; second level is 1.5x the held first
    always_comb
    begin
        thr2 = thr1_reg + {1'h0, thr1_reg[9:1]};
        // blank two cycles after low-side on: the node code lags the gate by the synchroniser
        oc_eval = gate_o.ls && ls_hist_reg[1] && ls_hist_reg[0];
        oc1 = oc_eval && (sw_mv > thr1_reg);
        oc2 = oc_eval && (sw_mv > thr2);
        run_ok = (st_reg == ST_SS) || (st_reg == ST_RUN);
        ls_mask = (st_reg == ST_SS) && !hs_started_reg;
        trip = run_ok && (oc2 || (tick && oc_seen_reg && (oc_cnt_reg == OC_COUNT - 3'h1)));
    end

    // switching tick and main sequencer next state
    always_comb
    begin
        tick = (tick_cnt_reg == 7'(TICK_CYC - 1));
        tick_cnt_next = tick ? 7'h00 : tick_cnt_reg + 7'h01;
        st_next = st_reg;
        ivl_next = ivl_reg;
        acc_next = acc_reg;
        ref_next = ref_reg;
        thr1_next = thr1_reg;
        hs_started_next = hs_started_reg | (drv_reg == DRV_HS_ON);
        oc_seen_next = (tick ? 1'h0 : oc_seen_reg) | oc1;
        oc_cnt_next = tick ? (oc_seen_reg ? oc_cnt_reg + 3'h1 : 3'h0) : oc_cnt_reg;
        thr_en_next = 1'h0;
        case (st_reg)
            ST_LOCKOUT:
            begin
                ivl_next = 11'h000;
                if (pin_reg.supply_ok && en_reg)
                    st_next = ST_THRSET;
            end
            ST_THRSET:
            begin
                thr_en_next = 1'h1;
                if (ls_mv >= CLAMP_MV)
                begin
                    thr1_next = THR_MAX_MV;
                    st_next = ST_SS;
                end
                else if (tick)
                begin
                    ivl_next = ivl_reg + 11'h001;
                    if (ivl_reg == 11'(THRESHOLD_SET_CURRENT_TICKS - 1))
                    begin
                        // hold the sampled pin voltage, clamped to the legal span
                        thr1_next = (ls_mv < THR_MIN_MV) ? THR_MIN_MV :
                                    (ls_mv > THR_MAX_MV) ? THR_MAX_MV : ls_mv;
                        st_next = ST_SS;
                    end
                end
                if (st_next == ST_SS)
                begin
                    ivl_next = 11'h000;
                    acc_next = 12'h000;
                    ref_next = 10'h000;
                    hs_started_next = 1'h0;
                    thr_en_next = 1'h0;
                end
            end
            ST_SS:
            begin
                // error-diffusion ramp, at most one millivolt per tick
                if (tick)
                begin
                    ivl_next = ivl_reg + 11'h001;
                    if (acc_reg + 12'(REF_MV) >= 12'(SS_TICKS))
                    begin
                        acc_next = acc_reg + 12'(REF_MV) - 12'(SS_TICKS);
                        ref_next = ref_reg + 10'h001;
                    end
                    else
                        acc_next = acc_reg + 12'(REF_MV);
                    if (ivl_reg == 11'(SS_TICKS - 1))
                    begin
                        ref_next = REF_MV;
                        st_next = ST_RUN;
                    end
                end
            end
            default:
                ;
        endcase
        if (trip)
            st_next = ST_FAULT;
        if (!run_ok)
        begin
            oc_seen_next = 1'h0;
            oc_cnt_next = 3'h0;
        end
        // only a trip through lockout clears the latch; disable cannot
        if (!pin_reg.supply_ok)
            st_next = ST_LOCKOUT;
        else if (!en_reg && st_reg != ST_FAULT)
            st_next = ST_LOCKOUT;
    end

    always_ff @(posedge core_clk_i or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            tick_cnt_reg <= 7'h00;
            st_reg <= ST_LOCKOUT;
            ivl_reg <= 11'h000;
            acc_reg <= 12'h000;
            ref_reg <= 10'h000;
            thr1_reg <= THR_MAX_MV;
            hs_started_reg <= 1'h0;
            oc_seen_reg <= 1'h0;
            oc_cnt_reg <= 3'h0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            st_reg <= st_next;
            ivl_reg <= ivl_next;
            acc_reg <= acc_next;
            ref_reg <= ref_next;
            thr1_reg <= thr1_next;
            hs_started_reg <= hs_started_next;
            oc_seen_reg <= oc_seen_next;
            oc_cnt_reg <= oc_cnt_next;
        end
    end

    // gate driver sequencing with adaptive dead time
    always_comb
    begin
        drv_next = drv_reg;
        wd_next = 8'h00;
        ls_hist_next = {ls_hist_reg[0], gate_o.ls};
        case (drv_reg)
            DRV_OFF:
                if (pin_reg.pwm_req)
                    drv_next = DRV_WAIT_LG;
                else if (!ls_mask)
                    drv_next = DRV_LS_ON;
            DRV_HS_ON:
                if (!pin_reg.pwm_req)
                    drv_next = DRV_WAIT_SW;
            DRV_WAIT_SW:
            begin
                wd_next = wd_reg + 8'h01;
                // negative inductor current keeps the node high; timer rescues it
                if (pin_reg.sw_node_low || wd_reg == 8'(WD_CYC_P - 1))
                    drv_next = ls_mask ? DRV_OFF : DRV_LS_ON;
            end
            DRV_LS_ON:
                if (pin_reg.pwm_req)
                    drv_next = DRV_WAIT_LG;
            default:
                if (pin_reg.ls_gate_low)
                    drv_next = pin_reg.pwm_req ? DRV_HS_ON : DRV_OFF;
        endcase
        if (!run_ok || trip)
            drv_next = DRV_OFF;
        // protection bypasses the startup mask but never the overcurrent latch
        gate_next.hs = (drv_next == DRV_HS_ON) && !pin_reg.prot_ls_on;
        gate_next.ls = ((drv_next == DRV_LS_ON) || pin_reg.prot_ls_on) && st_next != ST_FAULT
                       && st_next != ST_LOCKOUT;
        pg_oe_next = !(st_next == ST_RUN && pin_reg.sense_in_window);
    end

    always_ff @(posedge core_clk_i or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            drv_reg <= DRV_OFF;
            wd_reg <= 8'h00;
            ls_hist_reg <= 2'h0;
            gate_o <= '0;
            threshold_set_current_o <= 1'h0;
            power_ok_output_oe_o <= 1'h1;
        end
        else
        begin
            drv_reg <= drv_next;
            wd_reg <= wd_next;
            ls_hist_reg <= ls_hist_next;
            gate_o <= gate_next;
            threshold_set_current_o <= thr_en_next;
            power_ok_output_oe_o <= pg_oe_next;
        end
    end
    assign ref_mv_o = ref_reg;

    // avalon slave: one wait state, write commits on the released edge
    always_comb
    begin
        resp_next = (avs_read_i || avs_write_i) && !resp_reg;
        en_next = en_reg;
        rdata_next = rdata_reg;
        if (resp_reg && avs_write_i && avs_address_i == ADDR_CTRL && avs_byteenable_i[0])
            en_next = avs_writedata_i[CTRL_EN_BIT];
        if (avs_read_i && !resp_reg)
        begin
            if (avs_address_i == ADDR_CTRL)
                rdata_next = {31'h00000000, en_reg};
            else if (avs_address_i == ADDR_STATUS)
                rdata_next = {16'h0000, 3'h0, oc_cnt_reg, 1'h0, drv_reg, ls_mask, hs_started_reg, 1'h0, st_reg};
            else if (avs_address_i == ADDR_THRESH)
                rdata_next = {6'h00, thr2, 6'h00, thr1_reg};
            else
                rdata_next = 32'h00000000;
        end
    end
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !resp_reg;

    always_ff @(posedge core_clk_i or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            resp_reg <= 1'h0;
            en_reg <= CTRL_EN_RESET;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            resp_reg <= resp_next;
            en_reg <= en_next;
            rdata_reg <= rdata_next;
        end
    end
    assign avs_readdata_o = rdata_reg;

    // checks on sequencing and protection
    localparam int WD_BOUND = WD_CYC_P;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_sync);

    AST_TICK_PERIOD: assert property (tick |-> ##66 tick)
        else $error("tick period wrong");
    AST_LS_AFTER_NODE: assert property ($rose(gate_o.ls) && !$past(pin_reg.prot_ls_on) |->
        $past(drv_reg) == DRV_OFF || $past(pin_reg.sw_node_low) || $past(wd_reg) == 8'(WD_CYC_P - 1))
        else $error("low-side on without node drop");
    AST_HS_AFTER_LS: assert property ($rose(gate_o.hs) |-> $past(pin_reg.ls_gate_low) &&
        !$past(gate_o.ls)) else $error("high-side on before low-side gate fell");
    AST_FALLBACK: assert property (drv_reg == DRV_WAIT_SW |-> ##[1:WD_BOUND] drv_reg != DRV_WAIT_SW)
        else $error("fallback timer did not expire");
    AST_FAULT_HOLD: assert property (st_reg == ST_FAULT && pin_reg.supply_ok |=>
        st_reg == ST_FAULT ##1 !gate_o.hs && !gate_o.ls) else $error("fault latch released");
    AST_MASK: assert property (ls_mask && run_ok && !pin_reg.prot_ls_on |=> !gate_o.ls)
        else $error("low-side on during startup mask");
    AST_OC_COUNT: assert property (run_ok && pin_reg.supply_ok && tick && oc_seen_reg &&
        oc_cnt_reg == 3'h3 |=> st_reg == ST_FAULT) else $error("fourth overcurrent cycle missed");
    AST_OC_FAST: assert property (run_ok && oc2 && pin_reg.supply_ok |=> st_reg == ST_FAULT)
        else $error("second level did not trip");
    AST_CLAMP: assert property (st_reg == ST_THRSET && ls_mv >= CLAMP_MV && pin_reg.supply_ok
        && en_reg |=> st_reg == ST_SS && thr1_reg == THR_MAX_MV) else $error("clamp ignored");
    AST_REF_FULL: assert property (st_reg == ST_RUN |-> ref_reg == REF_MV)
        else $error("reference not at target in run");
    AST_PG: assert property (!power_ok_output_oe_o |-> st_reg == ST_RUN)
        else $error("power ok released early");

    COV_RUN: cover property (st_reg == ST_SS ##1 st_reg == ST_RUN);
    COV_TRIP: cover property (st_reg == ST_SS ##1 st_reg == ST_FAULT);
    COV_WD: cover property (drv_reg == DRV_WAIT_SW && wd_reg == 8'(WD_CYC_P - 1));
    COV_PREBIAS: cover property (st_reg == ST_RUN && !hs_started_reg);

endmodule // bsf_ctrl

// ==== bench/bsf_fet_model.sv ====
// model of the external switch pair: switch node and low-side gate pin
// assumes gate drive from the controller; load and pin levels come from the bench
`timescale 1ns/10ps
module bsf_fet_model
(
    input wire logic clk_i,
    input wire bsf_pkg::bsf_gate_type gate_i,
    input wire logic neg_cur_i,
    input wire logic [3:0] dly_i,
    input wire logic [9:0] load_mv_i,
    input wire logic [9:0] set_mv_i,
    input wire logic thr_cur_i,
    output logic sw_node_low_o,
    output logic ls_gate_low_o,
    output logic [9:0] sw_mv_o,
    output logic [9:0] lg_mv_o
);
    import bsf_pkg::*;
    int hs_off = 0;
    int ls_off = 0;
    logic flip = 1'b0;
    // node drops dly cycles after high-side off, never with reverse inductor current
    always @(posedge clk_i)
    begin
        hs_off <= gate_i.hs ? 0 : hs_off + 1;
        ls_off <= gate_i.ls ? 0 : ls_off + 1;
        flip <= ~flip;
        sw_node_low_o <= !gate_i.hs && hs_off >= dly_i && !neg_cur_i;
        ls_gate_low_o <= !gate_i.ls && ls_off >= dly_i;
    end
    // node moves high while low-side is off, so a stray compare would trip
    assign sw_mv_o = gate_i.ls ? load_mv_i : (flip ? 10'h3FF : 10'h2AA);
    // the pin reads full scale while low-side is on, otherwise rises only while the test current is sourced
    assign lg_mv_o = gate_i.ls ? 10'h3FF : (thr_cur_i ? set_mv_i : 10'h000);
endmodule // bsf_fet_model

// ==== bench/tb.sv ====
// self-checking bench for the buck startup and protection controller
// assumes bsf_ctrl, the switch model and a 20 MHz clock; drives Avalon-MM as master
`timescale 1ns/10ps
module tb;
    import bsf_pkg::*;
    localparam int WD = 12;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic supply_ok = 1'b0, pwm_req = 1'b0, prot_ls_on = 1'b0, in_win = 1'b1, neg_cur = 1'b0;
    logic [3:0] dly = 4'h1, addr = 4'h0, be = 4'hF;
    logic [9:0] load_mv = 10'h000, set_mv = 10'h2BC, sw_mv, lg_mv, ref_mv;
    logic rd = 1'b0, wr = 1'b0, nl, lgl, cur, oe, wreq, saw_cur = 1'b0, mon_on = 1'b0;
    logic ls_q = 1'b0, hs_q = 1'b0;
    logic [31:0] wdata = 32'h0, rdat, q;
    bsf_gate_type gate;
    int err_count = 0, total_checks = 0, nl_cnt = 0, lg_cnt = 0, hs_off = 0, cyc = 0, t_ss = 0;
    wire bsf_pins_type pins = {supply_ok, nl, lgl, pwm_req, prot_ls_on, in_win};

    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    bsf_ctrl #(.WD_CYC_P(WD)) u_dut (.core_clk_i(core_clk), .rstn_i(rstn), .pins_i(pins),
        .sw_node_mv_i(sw_mv), .ls_gate_mv_i(lg_mv), .gate_o(gate), .threshold_set_current_o(cur),
        .ref_mv_o(ref_mv), .power_ok_output_oe_o(oe), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq));
    bsf_fet_model u_fet (.clk_i(core_clk), .gate_i(gate), .neg_cur_i(neg_cur), .dly_i(dly),
        .load_mv_i(load_mv), .set_mv_i(set_mv), .thr_cur_i(cur), .sw_node_low_o(nl), .ls_gate_low_o(lgl),
        .sw_mv_o(sw_mv), .lg_mv_o(lg_mv));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // tolerance covers tick quantisation and polling latency
    task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
        total_checks++;
        if ((^got) === 1'bx || got < exp - tol || got > exp + tol)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus access; called just after a rising edge, leaves one idle edge after release
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0)
            err_count++;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_state(input logic [2:0] s, input int lim);
        int n = 0;
        bus(1'b0, ADDR_STATUS, 32'h0);
        while (q[2:0] !== s && n < lim)
        begin
            bus(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        chk({29'h0, q[2:0]}, {29'h0, s});
    endtask
    // supply through lockout clears any latch, then clamp-driven threshold setting
    task automatic cycle_supply();
        supply_ok <= 1'b0;
        prot_ls_on <= 1'b0;
        pwm_req <= 1'b0;
        load_mv <= 10'h000;
        repeat (8) @(posedge core_clk);
        wait_state(3'h0, 5);
        supply_ok <= 1'b1;
        wait_state(3'h2, 60);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // dead-time watch on the gates; counts taken between edges so they are settled
    always @(negedge core_clk)
    begin
        nl_cnt = pins.sw_node_low ? nl_cnt + 1 : 0;
        lg_cnt = pins.ls_gate_low ? lg_cnt + 1 : 0;
        hs_off = gate.hs ? 0 : hs_off + 1;
        if (cur === 1'b1)
            saw_cur = 1'b1;
        if (mon_on && gate.ls && !ls_q)
            chk(neg_cur ? hs_off >= WD : (nl_cnt >= 2 || hs_off >= WD), 1'b1);
        if (mon_on && gate.hs && !hs_q)
            chk(lg_cnt >= 2 && !gate.ls, 1'b1);
        if (mon_on)
            chk(gate.hs & gate.ls, 1'b0);
        ls_q = gate.ls;
        hs_q = gate.hs;
    end

    initial
    begin
        repeat (99000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(32'h41180D79));
        repeat (4) @(posedge core_clk);
        chk({gate, cur, oe, ref_mv, wreq}, 32'h800);
        rstn <= 1'b1;
        repeat (100) @(posedge core_clk);
        wait_state(3'h0, 1);
        chk(cur, 1'b0);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        be <= 4'h0;
        bus(1'b1, ADDR_CTRL, 32'h0);
        be <= 4'hF;
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h1);
        $display("test 1 reset and registers done");
        supply_ok <= 1'b1;
        wait_state(3'h2, 60);
        chk(saw_cur, 1'b1);
        bus(1'b0, ADDR_THRESH, 32'h0);
        chk(q, 32'h0339_0226);
        chk({gate, cur, oe}, 4'h1);
        prot_ls_on <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk(gate.ls, 1'b1);
        load_mv <= 10'h33A;
        repeat (6) @(posedge core_clk);
        chk(gate, 2'h0);
        pwm_req <= 1'b1;
        repeat (100) @(posedge core_clk);
        chk(gate, 2'h0);
        wait_state(3'h4, 1);
        $display("test 2 second level trip done");
        cycle_supply();
        prot_ls_on <= 1'b1;
        load_mv <= 10'h258;
        repeat (132) @(posedge core_clk);
        load_mv <= 10'h000;
        repeat (198) @(posedge core_clk);
        load_mv <= 10'h258;
        repeat (132) @(posedge core_clk);
        load_mv <= 10'h000;
        wait_state(3'h2, 1);
        load_mv <= 10'h258;
        repeat (400) @(posedge core_clk);
        wait_state(3'h4, 1);
        chk(gate, 2'h0);
        $display("test 3 first level count done");
        cycle_supply();
        t_ss = cyc;
        repeat (44550) @(posedge core_clk);
        chk_near(ref_mv, 675 * 800 / 1350, 5);
        chk(gate.ls, 1'b0);
        wait_state(3'h3, 16000);
        chk_near(cyc - t_ss, 89100, 140);
        chk(ref_mv, REF_MV);
        repeat (8) @(posedge core_clk);
        chk({gate.ls, oe}, 2'h2);
        in_win <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(oe, 1'b1);
        in_win <= 1'b1;
        $display("test 4 soft-start and pre-bias done");
        mon_on <= 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            neg_cur <= m[0];
            repeat (30)
            begin
                pwm_req <= ~pwm_req;
                dly <= 4'($urandom_range(1, 6));
                repeat ($urandom_range(20, 60)) @(posedge core_clk);
            end
        end
        mon_on <= 1'b0;
        wait_state(3'h3, 1);
        $display("test 5 dead time and fallback done");
        tally_and_finish();
    end
endmodule // tb
